// ---- rtl/usrc_pkg.sv ----
/*
  Package for the sleep, low-power and RS-485 control block: bit positions of
  the control registers, reset values, timing constants and state types.
  Assumes one 100 MHz clock domain and no register bus (bits arrive as ports).
*/
package usrc_pkg;

  // Bit positions inside the registers that the block watches, plus the line-status parity bit, which it does not use.
  localparam int unsigned EFR_SLEEP_EN_BIT   = 4;
  localparam int unsigned EFR_SPECIAL_BIT    = 5;
  localparam int unsigned IER_SLEEP_EN_BIT   = 4;
  localparam int unsigned IER_LINE_STAT_BIT  = 2;
  localparam int unsigned AFC1_IGNORE_RX_BIT = 4;
  localparam int unsigned AFC2_NINE_BIT      = 0;
  localparam int unsigned AFC2_AUTO_RTS_BIT  = 4;
  localparam int unsigned AFC2_RTS_INV_BIT   = 5;
  localparam int unsigned MCR_RTS_BIT        = 1;
  localparam int unsigned LSR_PARITY_BIT     = 2;

  // Reset values.
  localparam logic RTS_RESET      = 1'b1;
  localparam logic RX_EN_RESET    = 1'b0;

  // Timing: the clock period and the idle time on the serial input.
  localparam int unsigned CLOCK_PERIOD_NS = 10;
  localparam int unsigned IDLE_CHARS      = 4;
  localparam int unsigned BITS_PER_CHAR   = 10;
  localparam int unsigned BIT_TIME_NS     = 8680;
  localparam int unsigned BIT_CYCLES      = (BIT_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int unsigned IDLE_CYCLES     = IDLE_CHARS * BITS_PER_CHAR * BIT_CYCLES;

  // Wake delay after a start bit: four cycles restore sampling well before mid-bit.
  localparam int unsigned WAKE_LEAD_CYCLES = 4;

  // Received character path widths and buffer depth.
  localparam int unsigned CHAR_WIDTH = 8;
  localparam int unsigned FIFO_DEPTH = 32;

  // Power state machine, Gray coded along awake -> asleep -> low power.
  typedef enum logic [1:0] {
    USRC_AWAKE  = 2'b00,
    USRC_ASLEEP = 2'b01,
    USRC_LOW_POWER_PIN = 2'b11
  } usrc_power_t;

endpackage : usrc_pkg

// ---- rtl/usrc_fifo.sv ----
/*
  Synchronous FIFO with valid/ready handshakes on both sides.
  Assumes one clock, a synchronous active-high reset and a clock enable.
*/
`timescale 1ns/1ps
module usrc_fifo #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 32
) (
  input  wire logic             clock,
  input  wire logic             srst,
  input  wire logic             clk_en,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic                  empty
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  // Handshake terms; full and empty come straight from the count.
  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign empty     = (count == '0);
  assign out_data  = mem[rd_ptr];
  assign push      = clk_en && in_valid && in_ready;
  assign pop       = clk_en && out_valid && out_ready;

  // Storage write; no reset needed for the data array.
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers and occupancy.
  always_ff @(posedge clock) begin
    if (srst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  a_fifo_no_overflow: assert property (@(posedge clock) disable iff (srst)
    count <= (AW+1)'(DEPTH)) else $error("FIFO count passed its depth.");

endmodule : usrc_fifo

// ---- rtl/usrc_sync.sv ----
/*
  Two-flop synchroniser for a bus of pin inputs.
  Assumes the inputs are asynchronous to clock; the first stage feeds only the second.
*/
`timescale 1ns/1ps
module usrc_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input  wire logic             clock,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0]      sync_out
);
  logic [WIDTH-1:0] stage1;

  // Pin synchroniser; runs regardless of the clock enable so pins stay fresh.
  always_ff @(posedge clock) begin
    if (srst) begin
      stage1   <= INIT;
      sync_out <= INIT;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule : usrc_sync

// ---- rtl/usrc_ctrl.sv ----
/*
  Sleep, low-power and RS-485 control of a single-channel UART.
  Assumes: control register bits arrive as ports from the register file, the
  receiver hands in whole 9-bit characters, and the transmitter reports writes
  and end of shifting as one-cycle pulses on this clock.

*/
`timescale 1ns/1ps
module usrc_ctrl
  import usrc_pkg::*;
#(
  parameter int unsigned IDLE_COUNT = usrc_pkg::IDLE_CYCLES,
  parameter int unsigned DEPTH      = usrc_pkg::FIFO_DEPTH
) (
  input  wire logic                         clock,
  input  wire logic                         srst,
  input  wire logic                         clk_en,
  input  wire logic [7:0]                   enhanced_feature_reg,
  input  wire logic [7:0]                   interrupt_enable_reg,
  input  wire logic [7:0]                   advanced_feature_ctrl_one,
  input  wire logic [7:0]                   advanced_feature_ctrl_two,
  input  wire logic [7:0]                   modem_control_reg,
  input  wire logic [7:0]                   second_stop_char,
  input  wire logic                         flow_ctrl_en,
  input  wire logic                         flow_ctrl_rts,
  input  wire logic                         host_rx_enable,
  input  wire logic                         host_rx_disable,
  input  wire logic                         low_power_pin,
  input  wire logic                         serial_in,
  input  wire logic [3:0]                   modem_inputs,
  input  wire logic                         tx_write,
  input  wire logic                         tx_empty,
  input  wire logic                         tx_done,
  input  wire logic                         irq_pending,
  input  wire logic [usrc_pkg::CHAR_WIDTH:0] rx_char,
  input  wire logic                         rx_char_valid,
  input  wire logic                         rx_pop,
  output logic [usrc_pkg::CHAR_WIDTH-1:0]   rx_data,
  output logic                              rx_flag,
  output logic                              rx_data_valid,
  output logic                              rx_char_ready,
  output logic                              line_status_irq,
  output logic                              rx_enabled,
  output logic                              core_clk_en,
  output logic                              baud_clk_en,
  output logic                              host_isolate,
  output logic                              asleep,
  output logic                              rts_out
);
  import usrc_pkg::*;

  // The idle counter is 32 bits wide so that any sensible idle time fits.

  usrc_power_t                 power_state;
  usrc_power_t                 next_power_state;
  logic                        low_power_pin_s;
  logic                        serial_s;
  logic [3:0]                  modem_s;
  logic [3:0]                  modem_d;
  logic                        serial_d;
  logic [31:0]                 idle_cnt;
  logic                        line_idle;
  logic                        sleep_allowed;
  logic                        sleep_ready;
  logic                        modem_change;
  logic                        start_bit;
  logic                        wake_event;
  logic                        run;
  logic                        rts_busy;
  logic                        nine_bit;
  logic                        auto_detect;
  logic                        is_address;
  logic                        addr_match;
  logic                        store_char;
  logic                        next_rx_enabled;
  logic [CHAR_WIDTH:0]         fifo_in;
  logic [CHAR_WIDTH:0]         fifo_out;
  logic                        fifo_in_ready;
  logic                        fifo_empty;
  logic                        fifo_out_valid;

  // Pins from outside the clock domain pass two flip-flops first.
  usrc_sync #(.WIDTH(6), .INIT(6'h01)) u_sync (
    .clock   (clock),
    .srst    (srst),
    .async_in({low_power_pin, modem_inputs, serial_in}),
    .sync_out({low_power_pin_s, modem_s, serial_s})
  );

  // Run enable of the idle timer, RTS and receive path: a stopped clock or the low-power state is modelled as frozen state.
  assign run = clk_en && (power_state != USRC_LOW_POWER_PIN);

  // Edge history for wake detection; kept alive while asleep, as the pin
  // monitors of a sleeping part still watch the lines.
  always_ff @(posedge clock) begin
    if (srst) begin
      modem_d  <= 4'h0;
      serial_d <= 1'b1;
    end else if (clk_en) begin
      modem_d  <= modem_s;
      serial_d <= serial_s;
    end
  end

  assign modem_change = (modem_s != modem_d);
  assign start_bit    = serial_d && !serial_s;
  assign wake_event   = start_bit || tx_write || modem_change;

  // Idle-line timer: counts high cycles on the serial input up to four chars.
  always_ff @(posedge clock) begin
    if (srst) begin
      idle_cnt <= 32'h0;
    end else if (run) begin
      if (!serial_s) begin
        idle_cnt <= 32'h0;
      end else if (idle_cnt < IDLE_COUNT) begin
        idle_cnt <= idle_cnt + 32'h1;
      end
    end
  end

  assign line_idle = (idle_cnt >= IDLE_COUNT)
                     || advanced_feature_ctrl_one[AFC1_IGNORE_RX_BIT];
  assign sleep_allowed = enhanced_feature_reg[EFR_SLEEP_EN_BIT]
                         && interrupt_enable_reg[IER_SLEEP_EN_BIT];
  assign sleep_ready = sleep_allowed && line_idle && !modem_change
                       && tx_empty && !irq_pending && fifo_empty
                       && !tx_write && !rx_char_valid;

  // Power state: low power wins over everything, sleep repeats while enabled.
  always_comb begin
    next_power_state = power_state;
    case (power_state)
      USRC_AWAKE: begin
        if (low_power_pin_s) begin
          next_power_state = USRC_LOW_POWER_PIN;
        end else if (sleep_ready && !wake_event) begin
          next_power_state = USRC_ASLEEP;
        end
      end
      USRC_ASLEEP: begin
        if (low_power_pin_s) begin
          next_power_state = USRC_LOW_POWER_PIN;
        end else if (wake_event || !sleep_allowed) begin
          next_power_state = USRC_AWAKE;
        end
      end
      USRC_LOW_POWER_PIN: begin
        if (!low_power_pin_s) begin
          next_power_state = USRC_AWAKE;
        end
      end
      default: begin
        next_power_state = USRC_AWAKE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      power_state <= USRC_AWAKE;
    end else if (clk_en) begin
      power_state <= next_power_state;
    end
  end

  // Clock gate enables are registered; a start bit reopens them within one
  // cycle of the synchronised edge, far inside half a bit time.
  always_ff @(posedge clock) begin
    if (srst) begin
      core_clk_en  <= 1'b1;
      baud_clk_en  <= 1'b1;
      asleep       <= 1'b0;
      host_isolate <= 1'b0;
    end else if (clk_en) begin
      core_clk_en  <= (next_power_state == USRC_AWAKE);
      baud_clk_en  <= (next_power_state == USRC_AWAKE);
      asleep       <= (next_power_state == USRC_ASLEEP);
      host_isolate <= (next_power_state == USRC_LOW_POWER_PIN);
    end
  end

  // Transmitter busy flag for automatic driver control: set on a write,
  // cleared after the last bit; a write in the same cycle as done wins.
  always_ff @(posedge clock) begin
    if (srst) begin
      rts_busy <= 1'b0;
    end else if (run) begin
      if (tx_write) begin
        rts_busy <= 1'b1;
      end else if (tx_done) begin
        rts_busy <= 1'b0;
      end
    end
  end

  // Request-to-send source selection; the pin is active low, except in auto mode with the invert bit set, where it is active high.
  always_ff @(posedge clock) begin
    if (srst) begin
      rts_out <= RTS_RESET;
    end else if (run) begin
      if (advanced_feature_ctrl_two[AFC2_AUTO_RTS_BIT]) begin
        rts_out <= advanced_feature_ctrl_two[AFC2_RTS_INV_BIT]
                   ? (rts_busy || tx_write) : !(rts_busy || tx_write);
      end else if (flow_ctrl_en) begin
        rts_out <= flow_ctrl_rts;
      end else begin
        rts_out <= !modem_control_reg[MCR_RTS_BIT];
      end
    end
  end

  // Multidrop receive filter.
  assign nine_bit    = advanced_feature_ctrl_two[AFC2_NINE_BIT];
  assign auto_detect = nine_bit && enhanced_feature_reg[EFR_SPECIAL_BIT];
  assign is_address  = rx_char[CHAR_WIDTH];
  assign addr_match  = (rx_char[CHAR_WIDTH-1:0] == second_stop_char);

  always_comb begin
    store_char      = rx_char_valid;
    next_rx_enabled = rx_enabled;
    if (host_rx_enable) begin
      next_rx_enabled = 1'b1;
    end
    if (host_rx_disable) begin
      next_rx_enabled = 1'b0;
    end
    if (rx_char_valid && nine_bit) begin
      if (auto_detect) begin
        if (is_address && addr_match) begin
          next_rx_enabled = 1'b1;
        end else if (is_address) begin
          next_rx_enabled = 1'b0;
          store_char      = 1'b0;
        end else begin
          store_char = rx_enabled;
        end
      end else begin
        store_char = is_address || rx_enabled;
      end
    end
  end

  // Receiver enable; hardware auto-enable beats a simultaneous host clear.
  always_ff @(posedge clock) begin
    if (srst) begin
      rx_enabled <= RX_EN_RESET;
    end else if (run) begin
      rx_enabled <= next_rx_enabled;
    end
  end

  // Receive buffer; ready stalls the receiver when it fills.
  assign fifo_in = rx_char;
  usrc_fifo #(.WIDTH(CHAR_WIDTH + 1), .DEPTH(DEPTH)) u_fifo (
    .clock    (clock),
    .srst     (srst),
    .clk_en   (run),
    .in_data  (fifo_in),
    .in_valid (store_char && nine_bit || rx_char_valid && !nine_bit),
    .in_ready (fifo_in_ready),
    .out_data (fifo_out),
    .out_valid(fifo_out_valid),
    .out_ready(rx_pop && rx_data_valid),
    .empty    (fifo_empty)
  );

  // Output register of the receive path; the ninth bit rides in the
  // parity-error position, which covers both multidrop forms.
  always_ff @(posedge clock) begin
    if (srst) begin
      rx_data         <= '0;
      rx_flag         <= 1'b0;
      rx_data_valid   <= 1'b0;
      rx_char_ready   <= 1'b0;
      line_status_irq <= 1'b0;
    end else if (run) begin
      rx_data         <= fifo_out[CHAR_WIDTH-1:0];
      rx_flag         <= fifo_out[CHAR_WIDTH] && nine_bit;
      rx_data_valid   <= fifo_out_valid && !(rx_pop && rx_data_valid);
      rx_char_ready   <= fifo_in_ready;
      line_status_irq <= rx_char_valid && nine_bit && is_address && store_char
                         && interrupt_enable_reg[IER_LINE_STAT_BIT];
    end
  end

  sequence s_write_seen;
    tx_write && run && advanced_feature_ctrl_two[AFC2_AUTO_RTS_BIT]
      && !advanced_feature_ctrl_two[AFC2_RTS_INV_BIT];
  endsequence

  a_rts_on_write: assert property (@(posedge clock) disable iff (srst)
    s_write_seen |=> !rts_out) else $error("Auto RTS not driven low after write.");
  a_low_power_pin_isolate: assert property (@(posedge clock) disable iff (srst)
    clk_en && power_state == USRC_LOW_POWER_PIN |-> host_isolate && !core_clk_en)
    else $error("Low power did not stop clocks.");
  a_sleep_gated: assert property (@(posedge clock) disable iff (srst)
    clk_en && asleep |-> !baud_clk_en && !core_clk_en) else $error("Clock runs while asleep.");
  a_sleep_enable: assert property (@(posedge clock) disable iff (srst)
    $rose(asleep) |-> $past(sleep_allowed)) else $error("Slept without enable.");
  a_sleep_cond: assert property (@(posedge clock) disable iff (srst)
    $rose(asleep) |-> $past(fifo_empty) && $past(tx_empty) && !$past(irq_pending))
    else $error("Slept with work pending.");
  a_wake_event: assert property (@(posedge clock) disable iff (srst)
    clk_en && power_state == USRC_ASLEEP && wake_event && !low_power_pin_s |=> core_clk_en)
    else $error("Wake event ignored.");
  a_auto_drop: assert property (@(posedge clock) disable iff (srst)
    run && auto_detect && rx_char_valid && is_address && !addr_match |=> !rx_enabled)
    else $error("Non-matching address kept receiver on.");
  a_auto_enable: assert property (@(posedge clock) disable iff (srst)
    run && auto_detect && rx_char_valid && is_address && addr_match |=> rx_enabled)
    else $error("Matching address did not enable receiver.");

endmodule : usrc_ctrl

// ---- sim/usrc_station.sv ----
/*
  Remote multidrop station and line model: drives the serial line and hands
  received 9-bit characters to the block. Assumes the bench calls its tasks.
*/
`timescale 1ns/1ps
module usrc_station (
  input  wire logic  clock,
  input  wire logic  rdy,
  output logic       serial_in,
  output logic [8:0] rx_char,
  output logic       rx_char_valid
);
  // Set when the block never offered room for a character in time.
  logic stalled = 1'b0;

  // The line idles high and the character bus starts quiet.
  initial begin
    serial_in     = 1'b1;
    rx_char       = 9'h000;
    rx_char_valid = 1'b0;
  end

  // One character per call, offered once the block has room or after 50 cycles of waiting.
  task automatic send(input logic [8:0] c);
    for (int i = 0; i < 50 && rdy !== 1'b1; i++) @(negedge clock);
    if (rdy !== 1'b1) stalled = 1'b1;
    rx_char       = c;
    rx_char_valid = 1'b1;
    @(negedge clock);
    rx_char       = ~c; // Stale value is not left on a released bus.
    rx_char_valid = 1'b0;
  endtask : send

  // A start bit, then idle again, as a waking station would send it.
  task automatic start_bit();
    serial_in = 1'b0;
    repeat (8) @(negedge clock);
    serial_in = 1'b1;
  endtask : start_bit
endmodule : usrc_station

// ---- sim/usrc_ctrl_bench.sv ----
/*
  Self-checking bench for the sleep, low-power and RS-485 control block.
  Assumes the package constants and a station model driving the receive side.
*/
`timescale 1ns/1ps
module usrc_ctrl_bench;
  import usrc_pkg::*;
  logic clock = 1'b0, srst = 1'b1, clk_en = 1'b1;
  logic [7:0] feat_reg = 8'h00, int_en_reg = 8'h00, ctl_one = 8'h00, ctl_two = 8'h00;
  logic [7:0] modem_ctl = 8'h00, stop_char = 8'ha5;
  logic flow_en = 1'b0, flow_rts = 1'b1, rx_on = 1'b0, rx_off = 1'b0, lp_pin = 1'b0;
  logic [3:0] modem = 4'h0;
  logic tx_write = 1'b0, tx_empty = 1'b1, tx_done = 1'b0, irq = 1'b0, rx_pop = 1'b0;
  logic serial_in, rx_char_valid, rx_flag, rx_data_valid, rx_char_ready, line_status_irq;
  logic rx_enabled, core_clk_en, baud_clk_en, host_isolate, asleep, rts_out;
  logic [8:0] rx_char;
  logic [7:0] rx_data;
  int num_errors = 0, num_checks = 0, irqs = 0, n;

  usrc_ctrl #(.IDLE_COUNT(20), .DEPTH(32)) usrc_ctrl_inst (
    .clock(clock), .srst(srst), .clk_en(clk_en), .enhanced_feature_reg(feat_reg),
    .interrupt_enable_reg(int_en_reg), .advanced_feature_ctrl_one(ctl_one),
    .advanced_feature_ctrl_two(ctl_two), .modem_control_reg(modem_ctl),
    .second_stop_char(stop_char), .flow_ctrl_en(flow_en), .flow_ctrl_rts(flow_rts),
    .host_rx_enable(rx_on), .host_rx_disable(rx_off), .low_power_pin(lp_pin),
    .serial_in(serial_in), .modem_inputs(modem), .tx_write(tx_write), .tx_empty(tx_empty),
    .tx_done(tx_done), .irq_pending(irq), .rx_char(rx_char), .rx_char_valid(rx_char_valid),
    .rx_pop(rx_pop), .rx_data(rx_data), .rx_flag(rx_flag), .rx_data_valid(rx_data_valid),
    .rx_char_ready(rx_char_ready), .line_status_irq(line_status_irq), .rx_enabled(rx_enabled),
    .core_clk_en(core_clk_en), .baud_clk_en(baud_clk_en), .host_isolate(host_isolate),
    .asleep(asleep), .rts_out(rts_out));

  usrc_station usrc_station_inst (.clock(clock), .rdy(rx_char_ready), .serial_in(serial_in),
    .rx_char(rx_char), .rx_char_valid(rx_char_valid));

  // Free-running clock at 100 MHz.
  always #5 clock = ~clock;

  // Interrupt pulses are counted so a missing or doubled pulse shows up.
  always @(posedge clock) if (line_status_irq === 1'b1) irqs++;

  task automatic summarize();
    if (num_errors == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : summarize

  task automatic chk(input string s, input logic [8:0] e, input logic [8:0] g);
    num_checks++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
      num_errors++;
    end
  endtask : chk

  // Bounded wait on sleep (k=0) or isolation (k=1); a hang ends the run.
  task automatic wait_st(input bit k, input logic v);
    for (int i = 0; i < 200 && (k ? host_isolate : asleep) !== v; i++) @(negedge clock);
    chk(k ? "isolate" : "asleep", {8'h00, v}, {8'h00, k ? host_isolate : asleep});
    if ((k ? host_isolate : asleep) !== v) summarize();
  endtask : wait_st

  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clock);
    s = 1'b0;
  endtask : pulse

  // Send one character; a kept one must reach the head two cycles later.
  task automatic rx_expect(input logic [8:0] c, input logic keep);
    usrc_station_inst.send(c);
    chk("station_ready", 0, usrc_station_inst.stalled);
    if (usrc_station_inst.stalled) summarize();
    repeat (2) @(negedge clock);
    chk("rx_valid", {8'h00, keep}, {8'h00, rx_data_valid});
    if (keep) begin
      chk("rx_char", c, {rx_flag, rx_data});
      pulse(rx_pop);
      @(negedge clock);
    end
  endtask : rx_expect

  task automatic t_rts();
    clk_en = 1'b0;
    modem_ctl = 8'h02;
    repeat (2) @(negedge clock);
    chk("rts_frozen", 1, rts_out);
    clk_en = 1'b1;
    repeat (2) @(negedge clock);
    chk("rts_mcr", 0, rts_out);
    modem_ctl = 8'h00;
    flow_en = 1'b1;
    flow_rts = 1'b0;
    repeat (2) @(negedge clock);
    chk("rts_flow", 0, rts_out);
    flow_en = 1'b0;
    for (int inv = 0; inv < 2; inv++) begin
      ctl_two = inv ? 8'h30 : 8'h10;
      @(negedge clock);
      pulse(tx_write);
      chk("rts_busy", inv[0], rts_out);
      repeat (5) @(negedge clock);
      pulse(tx_done);
      @(negedge clock);
      chk("rts_done", !inv[0], rts_out);
    end
    ctl_two = 8'h00;
  endtask : t_rts

  task automatic t_sleep();
    feat_reg = 8'h10;
    repeat (60) @(negedge clock);
    chk("one_enable", 0, asleep);
    int_en_reg = 8'h10;
    wait_st(0, 1);
    chk("clocks_off", 0, {core_clk_en, baud_clk_en});
    pulse(tx_write);
    chk("wake_tx", 9'h003, {asleep, core_clk_en, baud_clk_en});
    wait_st(0, 1);
    modem = 4'h1;
    wait_st(0, 0);
    wait_st(0, 1);
    usrc_station_inst.start_bit();
    chk("wake_rx", 9'h003, {asleep, core_clk_en, baud_clk_en});
    irq = 1'b1;
    repeat (60) @(negedge clock);
    chk("irq_blocks", 0, asleep);
    irq = 1'b0;
    tx_empty = 1'b0;
    repeat (60) @(negedge clock);
    chk("tx_blocks", 0, asleep);
    tx_empty = 1'b1;
    wait_st(0, 1);
    ctl_one = 8'h10;
    usrc_station_inst.start_bit();
    repeat (4) @(negedge clock);
    chk("ignore_idle", 1, asleep);
    ctl_one = 8'h00;
    lp_pin = 1'b1;
    wait_st(1, 1);
    chk("lp_clocks", 0, {core_clk_en, baud_clk_en});
    lp_pin = 1'b0;
    wait_st(1, 0);
    int_en_reg = 8'h04;
    wait_st(0, 0);
  endtask : t_sleep

  task automatic t_multidrop();
    ctl_two = 8'h01;
    feat_reg = 8'h00;
    n = irqs;
    rx_expect(9'h042, 0);
    rx_expect(9'h1a5, 1);
    chk("irq_norm", n + 1, irqs);
    pulse(rx_on);
    chk("rx_on", 1, rx_enabled);
    rx_expect(9'h042, 1);
    rx_expect(9'h13c, 1);
    pulse(rx_off);
    flow_en = 1'b0;
    feat_reg = 8'h20;
    n = irqs;
    rx_expect(9'h13c, 0);
    rx_expect(9'h042, 0);
    rx_expect(9'h1a5, 1);
    chk("auto_on", 9'h101, {rx_enabled, irqs[7:0] - n[7:0]});
    rx_expect(9'h042, 1);
    rx_expect(9'h1a5, 1);
    rx_expect(9'h13c, 0);
    chk("auto_off", 0, rx_enabled);
    ctl_two = 8'h00;
  endtask : t_multidrop

  // Fill the receive buffer until it refuses, then drain it in order.
  task automatic t_fifo();
    n = 0;
    for (int i = 0; i < 40 && rx_char_ready === 1'b1; i++) begin
      usrc_station_inst.send(i[8:0]);
      @(negedge clock);
      n++;
    end
    chk("fifo_fill", FIFO_DEPTH, n);
    for (int i = 0; i < n; i++) begin
      chk("fifo_data", {1'b1, i[7:0]}, {rx_data_valid, rx_data});
      pulse(rx_pop);
      @(negedge clock);
    end
    chk("fifo_empty", 0, rx_data_valid);
  endtask : t_fifo

  initial begin
    repeat (3) @(negedge clock);
    srst = 1'b0;
    repeat (3) @(negedge clock);
    chk("reset", 9'h00e, {asleep, host_isolate, core_clk_en, baud_clk_en, rts_out, rx_enabled});
    t_rts();
    t_sleep();
    t_multidrop();
    t_fifo();
    summarize();
  end
endmodule : usrc_ctrl_bench
